// ===== common/fhu_pkg.sv
package fhu_pkg;
    localparam logic [7:0] FHU_OFS_HARD_STATUS  = 8'h00;
    localparam logic [7:0] FHU_OFS_MM_STATUS    = 8'h04;
    localparam logic [7:0] FHU_OFS_BUS_STATUS   = 8'h08;
    localparam logic [7:0] FHU_OFS_USAGE_STATUS = 8'h0c;
    localparam logic [7:0] FHU_OFS_MM_ADDR      = 8'h10;
    localparam logic [7:0] FHU_OFS_BUS_ADDR     = 8'h14;
    localparam logic [7:0] FHU_OFS_PRIORITY     = 8'h18;
    localparam logic [7:0] FHU_OFS_CONTROL      = 8'h1c;
    localparam logic [7:0] FHU_OFS_STATE        = 8'h20;
    // Status bit positions.
    localparam int FHU_B_VECTOR_READ_ERROR_FLAG      = 1;
    localparam int FHU_B_ESCALATED_FLAG    = 30;
    localparam int FHU_B_IACC      = 0;
    localparam int FHU_B_DACC      = 1;
    localparam int FHU_B_MUNSTK    = 3;
    localparam int FHU_B_MSTK      = 4;
    localparam int FHU_B_MMVALID   = 7;
    localparam int FHU_B_PREFETCH  = 0;
    localparam int FHU_B_PRECISE   = 1;
    localparam int FHU_B_DEFERRED  = 2;
    localparam int FHU_B_BUNSTK    = 3;
    localparam int FHU_B_BSTK      = 4;
    localparam int FHU_B_BVALID    = 7;
    localparam int FHU_B_UNDEFINED_OPCODE_FLAG     = 0;
    localparam int FHU_B_INVSTATE  = 1;
    localparam int FHU_B_BADRET    = 2;
    localparam int FHU_B_NO_COPROCESSOR_FLAG      = 3;
    localparam int FHU_B_MISALIGN  = 8;
    localparam int FHU_B_DIVIDE_BY_ZERO_FLAG      = 9;
    // Control bits: handler enables. Priority register: one byte per class.
    localparam int FHU_B_EN_MM     = 0;
    localparam int FHU_B_EN_BUS    = 1;
    localparam int FHU_B_EN_USAGE  = 2;
    localparam int FHU_PRI_MM_LSB    = 0;
    localparam int FHU_PRI_BUS_LSB   = 8;
    localparam int FHU_PRI_USAGE_LSB = 16;
    // State register bits.
    localparam int FHU_B_LOCKUP     = 0;
    localparam int FHU_B_LOCK_NMI   = 1;
    localparam logic [1:0] FHU_RESP_OKAY   = 2'b00;
    localparam logic [1:0] FHU_RESP_SLVERR = 2'b10;
    localparam logic [31:0] FHU_RESET_ZERO = 32'h0000_0000;
    // Fault class reported to the pipeline.
    typedef enum logic [2:0] {
        FHU_CLS_NONE,
        FHU_CLS_HARD,
        FHU_CLS_MM,
        FHU_CLS_BUS,
        FHU_CLS_USAGE
    } fhu_class_t;
    // Exception the core is currently executing.
    typedef enum logic [2:0] {
        FHU_EXC_THREAD,
        FHU_EXC_NMI,
        FHU_EXC_HARD,
        FHU_EXC_MM,
        FHU_EXC_BUS,
        FHU_EXC_USAGE,
        FHU_EXC_OTHER
    } fhu_exc_t;
endpackage

// ===== hdl/fhu_fault_unit.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module fhu_fault_unit
    import fhu_pkg::*;
#(
    parameter int PRI_W = 8
) (
    // Clock and reset.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Error events from bus, protection unit and pipeline.
    input  wire logic              vector_bus_err,
    input  wire logic              prefetch_bus_err,
    input  wire logic              precise_bus_err,
    input  wire logic              deferred_bus_err,
    input  wire logic              stacking_bus_err,
    input  wire logic              unstacking_bus_err,
    input  wire logic              non_executable_region,
    input  wire logic              mpu_instr_mismatch,
    input  wire logic              mpu_data_mismatch,
    input  wire logic              mpu_stacking_mismatch,
    input  wire logic              mpu_unstacking_mismatch,
    input  wire logic              coproc_access,
    input  wire logic              undefined_opcode,
    input  wire logic              invalid_state,
    input  wire logic              bad_return_value,
    input  wire logic              misaligned_access,
    input  wire logic              divide_by_zero,
    input  wire logic [31:0]       fault_addr,
    // Core context.
    input  wire fhu_exc_t          current_exc,
    input  wire logic [PRI_W-1:0]  current_pri,
    input  wire logic              entering_bus_handler,
    input  wire logic              nmi_req,
    input  wire logic              debug_halt,
    // Decisions to the pipeline.
    output logic                   fault_take,
    output fhu_class_t             fault_class,
    output logic                   fault_escalated,
    output logic                   hard_may_preempt,
    output logic                   lockup
);
    logic [31:0] hard_status_reg;
    logic [31:0] mm_status_reg;
    logic [31:0] bus_status_reg;
    logic [31:0] usage_status_reg;
    logic [31:0] mm_addr_reg;
    logic [31:0] bus_addr_reg;
    logic [31:0] priority_reg;
    logic [31:0] control_reg;
    logic        lockup_reg;
    logic        lock_nmi_reg;
    logic        take_reg;
    fhu_class_t  class_reg;
    logic        esc_reg;

    // Raw classification of this cycle's events.
    logic any_mm, mm_iacc, any_bus, any_usage, any_hard_direct;
    logic escalate, enabled, prio_blocked, bus_stack_exempt;
    fhu_class_t raw_class, final_class;
    logic [PRI_W-1:0] class_pri;

    assign mm_iacc   = mpu_instr_mismatch | non_executable_region;
    assign any_mm    = mm_iacc | mpu_data_mismatch | mpu_stacking_mismatch
                     | mpu_unstacking_mismatch;
    assign any_bus   = prefetch_bus_err | precise_bus_err | deferred_bus_err
                     | stacking_bus_err | unstacking_bus_err;
    assign any_usage = coproc_access | undefined_opcode | invalid_state
                     | bad_return_value | misaligned_access | divide_by_zero;
    assign any_hard_direct = vector_bus_err;

    // Only one class is reported per cycle; the most severe source wins.
    always_comb begin
        raw_class = FHU_CLS_NONE;
        enabled   = 1'b1;
        class_pri = '0;
        if (any_hard_direct) begin
            raw_class = FHU_CLS_HARD;
        end else if (any_mm) begin
            raw_class = FHU_CLS_MM;
            enabled   = control_reg[FHU_B_EN_MM];
            class_pri = priority_reg[FHU_PRI_MM_LSB +: PRI_W];
        end else if (any_bus) begin
            raw_class = FHU_CLS_BUS;
            enabled   = control_reg[FHU_B_EN_BUS];
            class_pri = priority_reg[FHU_PRI_BUS_LSB +: PRI_W];
        end else if (any_usage) begin
            raw_class = FHU_CLS_USAGE;
            enabled   = control_reg[FHU_B_EN_USAGE];
            class_pri = priority_reg[FHU_PRI_USAGE_LSB +: PRI_W];
        end
    end

    // A larger number is a lower priority, so equal or greater cannot preempt.
    // A handler of the same class runs at that class's priority, so its own
    // faults are caught by the equal-priority test as well.
    assign prio_blocked = (current_exc != FHU_EXC_THREAD)
                        && (class_pri >= current_pri);
    assign bus_stack_exempt = (raw_class == FHU_CLS_BUS) && stacking_bus_err
                            && entering_bus_handler;
    assign escalate = (raw_class != FHU_CLS_NONE) && (raw_class != FHU_CLS_HARD)
                    && !bus_stack_exempt && (!enabled || prio_blocked);
    assign final_class = escalate ? FHU_CLS_HARD : raw_class;

    assign hard_may_preempt = (current_exc != FHU_EXC_NMI)
                            && (current_exc != FHU_EXC_HARD);

    // Fault request to the pipeline, registered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            take_reg  <= 1'b0;
            class_reg <= FHU_CLS_NONE;
            esc_reg   <= 1'b0;
        end else begin
            take_reg  <= (final_class != FHU_CLS_NONE) && !lockup_reg;
            class_reg <= lockup_reg ? FHU_CLS_NONE : final_class;
            esc_reg   <= escalate && !lockup_reg;
        end
    end
    assign fault_take      = take_reg;
    assign fault_class     = class_reg;
    assign fault_escalated = esc_reg;

    // Lockup: a hard fault inside the critical handlers stops execution.
    logic hard_now;
    assign hard_now = (final_class == FHU_CLS_HARD);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lockup_reg   <= 1'b0;
            lock_nmi_reg <= 1'b0;
        end else if (!lockup_reg) begin
            if (hard_now && !hard_may_preempt) begin
                lockup_reg   <= 1'b1;
                lock_nmi_reg <= (current_exc == FHU_EXC_NMI);
            end
        end else if (debug_halt || (nmi_req && !lock_nmi_reg)) begin
            lockup_reg   <= 1'b0;
            lock_nmi_reg <= 1'b0;
        end
    end
    assign lockup = lockup_reg;

    // AXI4-Lite write side. Address and data are taken in either order.
    logic       aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic [31:0] w_mask;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign w_mask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= FHU_OFS_STATE);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FHU_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? FHU_RESP_OKAY : FHU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic wr_hit(input logic fire, input logic [7:0] a,
                                    input logic [7:0] ofs);
        wr_hit = fire && (a == ofs);
    endfunction

    // Writable configuration.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            priority_reg <= FHU_RESET_ZERO;
        end else if (wr_hit(wr_fire, aw_addr, FHU_OFS_PRIORITY)) begin
            priority_reg <= (priority_reg & ~w_mask) | (w_data & w_mask);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg <= FHU_RESET_ZERO;
        end else if (wr_hit(wr_fire, aw_addr, FHU_OFS_CONTROL)) begin
            control_reg <= (control_reg & ~w_mask) | (w_data & w_mask);
        end
    end

    // Sticky status flags: write one to clear, a new event wins over a clear.
    function automatic logic [31:0] w1c(input logic [31:0] cur, input logic hit,
                                        input logic [31:0] clr, input logic [31:0] set);
        w1c = (cur & ~(hit ? clr : 32'h0000_0000)) | set;
    endfunction

    logic [31:0] hard_set, mm_set, bus_set, usage_set;
    logic        log_en;
    assign log_en = !lockup_reg;

    always_comb begin
        hard_set  = '0;
        mm_set    = '0;
        bus_set   = '0;
        usage_set = '0;
        if (log_en) begin
            hard_set[FHU_B_VECTOR_READ_ERROR_FLAG]       = vector_bus_err;
            hard_set[FHU_B_ESCALATED_FLAG]     = escalate;
            mm_set[FHU_B_IACC]         = mm_iacc;
            mm_set[FHU_B_DACC]         = mpu_data_mismatch;
            mm_set[FHU_B_MSTK]         = mpu_stacking_mismatch;
            mm_set[FHU_B_MUNSTK]       = mpu_unstacking_mismatch;
            mm_set[FHU_B_MMVALID]      = mpu_data_mismatch;
            bus_set[FHU_B_PREFETCH]    = prefetch_bus_err;
            bus_set[FHU_B_PRECISE]     = precise_bus_err;
            bus_set[FHU_B_DEFERRED]    = deferred_bus_err;
            bus_set[FHU_B_BSTK]        = stacking_bus_err;
            bus_set[FHU_B_BUNSTK]      = unstacking_bus_err;
            bus_set[FHU_B_BVALID]      = precise_bus_err;
            usage_set[FHU_B_UNDEFINED_OPCODE_FLAG]     = undefined_opcode;
            usage_set[FHU_B_NO_COPROCESSOR_FLAG]      = coproc_access;
            usage_set[FHU_B_INVSTATE]  = invalid_state;
            usage_set[FHU_B_BADRET]    = bad_return_value;
            usage_set[FHU_B_MISALIGN]  = misaligned_access;
            usage_set[FHU_B_DIVIDE_BY_ZERO_FLAG]      = divide_by_zero;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hard_status_reg <= FHU_RESET_ZERO;
        end else begin
            hard_status_reg <= w1c(hard_status_reg, wr_hit(wr_fire, aw_addr,
                                   FHU_OFS_HARD_STATUS), w_data & w_mask, hard_set);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mm_status_reg <= FHU_RESET_ZERO;
        end else begin
            mm_status_reg <= w1c(mm_status_reg, wr_hit(wr_fire, aw_addr,
                                 FHU_OFS_MM_STATUS), w_data & w_mask, mm_set);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_status_reg <= FHU_RESET_ZERO;
        end else begin
            bus_status_reg <= w1c(bus_status_reg, wr_hit(wr_fire, aw_addr,
                                  FHU_OFS_BUS_STATUS), w_data & w_mask, bus_set);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usage_status_reg <= FHU_RESET_ZERO;
        end else begin
            usage_status_reg <= w1c(usage_status_reg, wr_hit(wr_fire, aw_addr,
                                    FHU_OFS_USAGE_STATUS), w_data & w_mask, usage_set);
        end
    end

    // Address capture. Only accesses with a known address load the registers;
    // deferred bus errors have lost their address by the time they arrive.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mm_addr_reg <= FHU_RESET_ZERO;
        end else if (mm_set[FHU_B_MMVALID]) begin
            mm_addr_reg <= fault_addr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_addr_reg <= FHU_RESET_ZERO;
        end else if (bus_set[FHU_B_BVALID]) begin
            bus_addr_reg <= fault_addr;
        end
    end

    // AXI4-Lite read side: one read in flight, data one cycle after address.
    logic [31:0] rd_value;
    always_comb begin
        case (s_axi_araddr)
            FHU_OFS_HARD_STATUS:  rd_value = hard_status_reg;
            FHU_OFS_MM_STATUS:    rd_value = mm_status_reg;
            FHU_OFS_BUS_STATUS:   rd_value = bus_status_reg;
            FHU_OFS_USAGE_STATUS: rd_value = usage_status_reg;
            FHU_OFS_MM_ADDR:      rd_value = mm_addr_reg;
            FHU_OFS_BUS_ADDR:     rd_value = bus_addr_reg;
            FHU_OFS_PRIORITY:     rd_value = priority_reg;
            FHU_OFS_CONTROL:      rd_value = control_reg;
            FHU_OFS_STATE: begin
                rd_value = '0;
                rd_value[FHU_B_LOCKUP]   = lockup_reg;
                rd_value[FHU_B_LOCK_NMI] = lock_nmi_reg;
            end
            default:              rd_value = '0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= FHU_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? FHU_RESP_OKAY : FHU_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // fhu_fault_unit

// ===== verification/fhu_core_model.sv
`timescale 1ns/1ps
module fhu_core_model (
    // Clock and reset.
    input wire logic        aclk,
    input wire logic        aresetn,
    // Command from the bench.
    input wire logic        fire,
    input wire logic [4:0]  fire_idx,
    // Event lines into the fault unit.
    output logic [16:0]     ev
);
    initial ev = 17'h0_0000;
    // Events are single-cycle pulses, since the pipeline reports each failed access once.
    always @(posedge aclk) begin
        ev <= 17'h0_0000;
        if (aresetn && fire) begin
            ev[fire_idx] <= 1'b1;
        end
    end
endmodule // fhu_core_model

// ===== verification/fhu_fault_unit_assertions.sv
`timescale 1ns/1ps
module fhu_fault_checker
    import fhu_pkg::*;
(
    // Clock and reset.
    input wire logic       aclk,
    input wire logic       aresetn,
    // Events and context.
    input wire logic       vector_bus_err,
    input wire logic       non_executable_region,
    input wire logic       divide_by_zero,
    input wire fhu_exc_t   current_exc,
    input wire logic       nmi_req,
    input wire logic       debug_halt,
    // Decisions.
    input wire logic       fault_take,
    input wire fhu_class_t fault_class,
    input wire logic       fault_escalated,
    input wire logic       hard_may_preempt,
    input wire logic       lockup
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    vector_read_error_flag_hard_a: assert property (vector_bus_err && !lockup |=>
        fault_take && fault_class == FHU_CLS_HARD) else $error("vector error not hard");
    div_take_a: assert property (divide_by_zero && !lockup |=> fault_take)
        else $error("divide by zero not taken");
    xn_mm_a: assert property (non_executable_region && !lockup && !vector_bus_err |=>
        fault_take && (fault_class == FHU_CLS_MM || fault_escalated))
        else $error("non-executable fetch not a memory fault");
    esc_hard_a: assert property (fault_escalated |->
        fault_take && fault_class == FHU_CLS_HARD) else $error("escalation not hard");
    lock_enter_a: assert property (vector_bus_err && !lockup &&
        current_exc inside {FHU_EXC_NMI, FHU_EXC_HARD} |=> lockup) else $error("no lockup");
    lock_hold_a: assert property (lockup && !nmi_req && !debug_halt |=> lockup)
        else $error("lockup left without cause");
    halt_exit_a: assert property (lockup && debug_halt |=> !lockup)
        else $error("debug halt did not end lockup");
    lock_quiet_a: assert property (lockup |=> !fault_take)
        else $error("fault taken in lockup");
    hard_preempt_a: assert property (hard_may_preempt ==
        !(current_exc inside {FHU_EXC_NMI, FHU_EXC_HARD})) else $error("preempt level wrong");
    cover property (fault_escalated);
    cover property ($rose(lockup));
    cover property (fault_take && fault_class == FHU_CLS_USAGE);
endmodule // fhu_fault_checker
bind fhu_fault_unit fhu_fault_checker i_chk (
    .aclk, .aresetn, .vector_bus_err, .non_executable_region, .divide_by_zero, .current_exc,
    .nmi_req, .debug_halt, .fault_take, .fault_class, .fault_escalated, .hard_may_preempt,
    .lockup
);

// ===== verification/test_processor_fault_handling_unit.sv
`timescale 1ns/1ps
module test_processor_fault_handling_unit
    import fhu_pkg::*;
;
    localparam logic [31:0] ADDR = 32'h2000_0104;
    localparam int          BITS [17] = '{1, 0, 1, 2, 4, 3, 0, 0, 1, 4, 3, 3, 0, 1, 2, 8, 9};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  strb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, take, esc, hmp, lockup;
    logic [1:0]  bresp, rresp, wr_r, rd_r;
    logic [31:0] rdata, rd_d;
    logic        fire = 1'b0;
    logic [4:0]  fidx = 5'h00;
    logic [16:0] ev;
    logic [1:0]  rel = 2'b00;
    logic        entering = 1'b0;
    logic [7:0]  cur_pri = 8'h00;
    logic [7:0]  ofs;
    fhu_exc_t    cur_exc = FHU_EXC_THREAD;
    fhu_class_t  cls, c;
    int          errors = 0, compares = 0, cyc = 0;
    always #20 aclk = ~aclk;
    fhu_core_model i_core (.aclk(aclk), .aresetn(aresetn), .fire(fire), .fire_idx(fidx), .ev(ev));
    fhu_fault_unit i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .vector_bus_err(ev[0]), .prefetch_bus_err(ev[1]), .precise_bus_err(ev[2]),
        .deferred_bus_err(ev[3]), .stacking_bus_err(ev[4]), .unstacking_bus_err(ev[5]),
        .non_executable_region(ev[6]), .mpu_instr_mismatch(ev[7]), .mpu_data_mismatch(ev[8]),
        .mpu_stacking_mismatch(ev[9]), .mpu_unstacking_mismatch(ev[10]),
        .coproc_access(ev[11]), .undefined_opcode(ev[12]), .invalid_state(ev[13]),
        .bad_return_value(ev[14]), .misaligned_access(ev[15]), .divide_by_zero(ev[16]),
        .fault_addr(ADDR), .current_exc(cur_exc), .current_pri(cur_pri),
        .entering_bus_handler(entering), .nmi_req(rel[0]), .debug_halt(rel[1]),
        .fault_take(take), .fault_class(cls), .fault_escalated(esc),
        .hard_may_preempt(hmp), .lockup(lockup)
    );
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        strb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        chk(rd_d, exp);
    endtask
    task automatic ctx(input fhu_exc_t e, input logic [7:0] p, input logic en);
        @(posedge aclk);
        cur_exc <= e;
        cur_pri <= p;
        entering <= en;
    endtask
    task automatic fire_chk(input int i, input logic t, input fhu_class_t k, input logic e);
        @(posedge aclk);
        fire <= 1'b1;
        fidx <= i[4:0];
        @(posedge aclk);
        fire <= 1'b0;
        @(posedge aclk);
        #1;
        chk(take, t);
        if (t) chk({cls, esc}, {k, e});
    endtask
    task automatic rel_pulse(input logic [1:0] v, input logic lk);
        @(posedge aclk);
        rel <= v;
        @(posedge aclk);
        rel <= 2'b00;
        #1;
        chk(lockup, lk);
    endtask
    // A hang in any handshake ends the run here; the whole sequence needs under 2000 cycles.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int o = 0; o <= 32; o += 4) rchk(o[7:0], 32'h0);
        rchk(8'h24, 32'h0);
        chk(rd_r, FHU_RESP_SLVERR);
        wr(8'h24, 32'h1);
        chk(wr_r, FHU_RESP_SLVERR);
        $display("reset test done");
        fire_chk(16, 1, FHU_CLS_HARD, 1);
        wr(FHU_OFS_CONTROL, 32'h3);
        rchk(FHU_OFS_CONTROL, 32'h3);
        fire_chk(16, 1, FHU_CLS_HARD, 1);
        fire_chk(1, 1, FHU_CLS_BUS, 0);
        rchk(FHU_OFS_HARD_STATUS, 32'h4000_0000);
        for (int o = 0; o < 16; o += 4) wr(o[7:0], 32'hffff_ffff);
        wr(FHU_OFS_CONTROL, 32'h7);
        wr(FHU_OFS_PRIORITY, 32'h0020_2020);
        rchk(FHU_OFS_PRIORITY, 32'h0020_2020);
        $display("enable test done");
        for (int i = 0; i < 17; i++) begin
            ofs = i == 0 ? 8'h00 : i < 6 ? 8'h08 : i < 11 ? 8'h04 : 8'h0c;
            c = i == 0 ? FHU_CLS_HARD : i < 6 ? FHU_CLS_BUS : i < 11 ? FHU_CLS_MM : FHU_CLS_USAGE;
            fire_chk(i, 1, c, 0);
            rchk(ofs, (32'h1 << BITS[i]) | ((i == 2 || i == 8) ? 32'h80 : 32'h0));
            if (i == 2 || i == 8) rchk(i == 2 ? 8'h14 : 8'h10, ADDR);
            wr(ofs, 32'hffff_ffff);
        end
        $display("cause test done");
        for (int k = 0; k < 3; k++) begin
            ctx(FHU_EXC_OTHER, 8'h1f + k[7:0], 1'b0);
            fire_chk(16, 1, k == 2 ? FHU_CLS_USAGE : FHU_CLS_HARD, k != 2);
        end
        ctx(FHU_EXC_USAGE, 8'h20, 1'b0);
        fire_chk(16, 1, FHU_CLS_HARD, 1);
        ctx(FHU_EXC_BUS, 8'h20, 1'b1);
        fire_chk(4, 1, FHU_CLS_BUS, 0);
        ctx(FHU_EXC_BUS, 8'h20, 1'b0);
        fire_chk(4, 1, FHU_CLS_HARD, 1);
        $display("escalation test done");
        ctx(FHU_EXC_HARD, 8'h00, 1'b0);
        fire_chk(0, 1, FHU_CLS_HARD, 0);
        chk(lockup, 1'b1);
        fire_chk(16, 0, FHU_CLS_NONE, 0);
        rel_pulse(2'b01, 1'b0);
        ctx(FHU_EXC_NMI, 8'h00, 1'b0);
        fire_chk(0, 1, FHU_CLS_HARD, 0);
        rchk(FHU_OFS_STATE, 32'h3);
        rel_pulse(2'b01, 1'b1);
        rel_pulse(2'b10, 1'b0);
        $display("lockup test done");
        for (int e = 0; e < 7; e++) begin
            ctx(fhu_exc_t'(e), 8'h00, 1'b0);
            #1;
            chk(hmp, e != 1 && e != 2);
        end
        wr(FHU_OFS_PRIORITY, 32'hffff_ffff, 4'h2);
        rchk(FHU_OFS_PRIORITY, 32'h0020_ff20);
        $display("preempt test done");
        print_verdict();
    end
endmodule // test_processor_fault_handling_unit
